// [bench/fea_framer_model.sv]
/*
  Behavioural receive framer that hands C13 overhead bits to the receiver with a strobe.
  Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/10ps
module fea_framer_model
  import fea_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_bit_valid,
  output logic      o_bit
);
  // ****************************************************************
  // Bit delivery
  // ****************************************************************
  int gap = 2;  // Idle cycles before each strobe; the bench varies it.

  // The line rests low-strobe from time zero.
  initial
  begin
    o_bit_valid = 1'b0;
    o_bit       = 1'b0;
  end

  // Off the strobe the line shows the inverse bit, so a stale value never passes for data.
  task send_bit(input logic b);
    repeat (gap) @(posedge i_clk);
    while (i_rst_n !== 1'b1)
      @(posedge i_clk);
    o_bit_valid <= 1'b1;
    o_bit       <= b;
    @(posedge i_clk);
    o_bit_valid <= 1'b0;
    o_bit       <= ~b;
  endtask : send_bit

  // Sixteen bits go out least significant first, the order the channel carries.
  task send_raw(input logic [15:0] p);
    for (int i = 0; i < 16; i++)
      send_bit(p[i]);
  endtask : send_raw

  // A complete pattern: eight ones, a zero, the six code bits, a closing zero.
  task send_word(input logic [5:0] c);
    send_raw({1'b0, c, 1'b0, FEA_PAT_ONES});
  endtask : send_word

  // A run of ones, as the idle channel carries.
  task send_ones(input int n);
    repeat (n) send_bit(1'b1);
  endtask : send_ones
endmodule : fea_framer_model

// [bench/tb.sv]
/*
  Self-checking bench for the alarm code receiver: register access, detection modes,
  idle, flags, code stack and interrupt line. Assumes the framer model beside it.
*/
`timescale 1ns/10ps
module tb
  import fea_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        oh_valid;
  logic        oh_bit;
  logic [2:0]  mode;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_req;
  logic        irq;
  logic [31:0] d;
  logic [5:0]  w [$];
  logic [5:0]  a, b, c, x;
  logic        e;
  logic [5:0]  m_tent;
  logic [5:0]  m_alt;
  int          m_st;
  int          m_cnt;
  int          k;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;

  fea_receiver dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_oh_bit_valid(oh_valid),
    .i_oh_bit(oh_bit), .i_framing_mode(mode), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_irq(irq));
  fea_framer_model fr_u (.i_clk(clk), .i_rst_n(rst_n), .o_bit_valid(oh_valid), .o_bit(oh_bit));

  // ****************************************************************
  // Clock, timeout and reporting
  // ****************************************************************
  always #20 clk = ~clk;

  // The ceiling is several times the expected run, so only a hang reaches it.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      end_sim();
    end
  end

  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, ex, got);
    end
  endtask : chk

  // ****************************************************************
  // Avalon master: request held until waitrequest is sampled low
  // ****************************************************************
  task av_write(input logic [4:0] ad, input logic [31:0] v);
    @(posedge clk);
    addr  <= ad;
    wdata <= v;
    wr    <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    wr <= 1'b0;
  endtask : av_write

  task av_read(input logic [4:0] ad, output logic [31:0] v);
    @(posedge clk);
    addr <= ad;
    rd   <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    v  = rdata;
    rd <= 1'b0;
  endtask : av_read

  task rd_chk(input logic [4:0] ad, input logic [31:0] ex, input string n);
    av_read(ad, d);
    chk(n, ex, d);
  endtask : rd_chk

  // The interrupt is registered, so two edges let it settle.
  task irq_chk(input logic ex);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, ex}, {31'h0, irq});
  endtask : irq_chk

  // ****************************************************************
  // Expected values
  // ****************************************************************
  function automatic logic [31:0] st_exp(logic n, logic i, logic s, logic m);
    logic [31:0] r;
    r = 32'h0;
    r[FEA_STAT_NEW]  = n;
    r[FEA_STAT_IDLE] = i;
    r[FEA_STAT_SNE]  = s;
    r[FEA_STAT_MSG]  = m;
    return r;
  endfunction : st_exp

  function automatic logic [31:0] code_exp(logic [5:0] cw);
    return {24'h0, 1'b0, cw, 1'b0};
  endfunction : code_exp

  function automatic logic [31:0] stk_exp(logic [5:0] cw, logic v, logic m);
    return {24'h0, m, v, cw};
  endfunction : stk_exp

  // Reference tracker for multiple detection; returns 1 when a word becomes valid.
  function automatic logic trk_step(input logic [5:0] cw);
    logic hit;
    hit = 1'b0;
    if (m_st == 0)
    begin
      m_tent = cw;
      m_cnt  = 1;
      m_st   = 1;
    end
    else if (cw == m_tent)
    begin
      m_cnt = m_cnt + ((m_st == 2) ? 2 : 1);
      m_st  = 1;
      hit   = 1'b1;
    end
    else if (m_st == 1)
    begin
      m_alt = cw;
      m_st  = 2;
    end
    else
    begin
      m_cnt  = (cw == m_alt) ? 2 : 1;
      m_st   = (cw == m_alt) ? 1 : 2;
      m_tent = m_alt;
      m_alt  = cw;
    end
    hit = hit && (m_cnt >= 9);
    if (hit)
      m_st = 0;
    return hit;
  endfunction : trk_step

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    clk   = 1'b0;
    rst_n = 1'b0;
    mode  = FEA_FRM_CBIT;
    addr  = 5'h00;
    rd    = 1'b0;
    wr    = 1'b0;
    wdata = 32'h0;
    m_st  = 0;
    void'($urandom(73));
    a = 6'($urandom);
    b = a ^ 6'h15;
    c = a ^ 6'h2A;
    x = a ^ 6'h3F;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, a refused write and an unmapped address.
    rd_chk(FEA_ADDR_CTRL, {28'h0, FEA_CTRL_RESET}, "ctrl");
    rd_chk(FEA_ADDR_STACK, 32'h0, "empty stack");
    av_write(FEA_ADDR_STATUS, 32'hFF);
    rd_chk(FEA_ADDR_STATUS, 32'h0, "status");
    rd_chk(5'h10, 32'h0, "unmapped");
    $display("test reset done");
    // Single detection, flag clear on read, overwrite, faulty overhead, idle.
    av_write(FEA_ADDR_CTRL, 32'h1 << FEA_CTRL_SINGLE);
    fr_u.send_word(a);
    rd_chk(FEA_ADDR_STATUS, st_exp(1, 0, 1, 1), "status");
    rd_chk(FEA_ADDR_CODE, code_exp(a), "code byte");
    rd_chk(FEA_ADDR_STATUS, st_exp(0, 0, 1, 1), "status");
    fr_u.send_word(b);
    fr_u.send_word(c);
    rd_chk(FEA_ADDR_CODE, code_exp(c), "code byte");
    fr_u.send_raw(16'h0000);
    fr_u.send_raw({1'b0, x, 1'b0, 8'hF7});
    rd_chk(FEA_ADDR_STATUS, st_exp(0, 0, 1, 1), "status");
    fr_u.send_ones(15);
    rd_chk(FEA_ADDR_STATUS, st_exp(0, 0, 1, 1), "status");
    fr_u.send_ones(1);
    rd_chk(FEA_ADDR_STATUS, st_exp(0, 1, 1, 0), "status");
    rd_chk(FEA_ADDR_STATUS, st_exp(0, 0, 1, 0), "status");
    for (int m = 0; m < 5; m++)
    begin
      @(posedge clk);
      mode <= (m == 2) ? FEA_FRM_M13 : m[2:0];
      fr_u.send_word(a);
      rd_chk(FEA_ADDR_STATUS, st_exp(0, 0, 1, 0), "status other mode");
    end
    @(posedge clk);
    mode <= FEA_FRM_CBIT;
    $display("test single done");
    // Stack: push reasons, overrun of the oldest, pops in order.
    repeat (4) av_read(FEA_ADDR_STACK, d);
    w = {a, a, b, c, x};
    foreach (w[i])
      fr_u.send_word(w[i]);
    rd_chk(FEA_ADDR_STATUS, st_exp(1, 0, 1, 1), "status");
    rd_chk(FEA_ADDR_STACK, stk_exp(b, 1, 1), "stack");
    rd_chk(FEA_ADDR_STACK, stk_exp(c, 1, 1), "stack");
    rd_chk(FEA_ADDR_STACK, stk_exp(x, 1, 0), "stack");
    rd_chk(FEA_ADDR_STACK, 32'h0, "stack");
    rd_chk(FEA_ADDR_STATUS, st_exp(1, 0, 0, 1), "status");
    fr_u.send_word(x);
    fr_u.send_word(x);
    fr_u.send_ones(16);
    fr_u.send_word(x);
    rd_chk(FEA_ADDR_STACK, stk_exp(x, 1, 1), "stack");
    rd_chk(FEA_ADDR_STACK, stk_exp(x, 1, 0), "stack");
    $display("test stack done");
    // Interrupt masking of stack and new-message events.
    av_write(FEA_ADDR_CTRL, 32'h9);
    irq_chk(1'b0);
    fr_u.send_word(b);
    irq_chk(1'b1);
    av_write(FEA_ADDR_CTRL, 32'h3);
    rd_chk(FEA_ADDR_CTRL, 32'h3, "ctrl");
    irq_chk(1'b1);
    rd_chk(FEA_ADDR_CODE, code_exp(b), "code byte");
    irq_chk(1'b0);
    // The idle seen in the stack test left the return flag up; unmask it alone.
    av_write(FEA_ADDR_CTRL, 32'h4);
    irq_chk(1'b1);
    rd_chk(FEA_ADDR_STATUS, st_exp(0, 1, 1, 1), "status");
    irq_chk(1'b0);
    $display("test irq done");
    // Multiple detection: hand corners first, then random runs.
    av_write(FEA_ADDR_CTRL, 32'h0);
    @(posedge clk);
    mode <= FEA_FRM_M13;
    @(posedge clk);
    mode <= FEA_FRM_CBIT;
    w = {a, a, a, a, a, a, a, a, a, a, b, a, a, a, a, a, a, a, a, b, b, b, b, b, b, b, b, b,
         b, a, b, c, b, b, b, b, b, b, b};
    repeat (48)
    begin
      k = $urandom % 8;
      w.push_back((k < 5) ? a : ((k < 7) ? b : c));
    end
    foreach (w[i])
    begin
      fr_u.gap = 1 + $urandom % 3;
      fr_u.send_word(w[i]);
      e = trk_step(w[i]);
      av_read(FEA_ADDR_STATUS, d);
      chk("new flag", {31'h0, e}, {31'h0, d[FEA_STAT_NEW]});
      av_read(FEA_ADDR_CODE, d);
      if (e)
        chk("code byte", code_exp(w[i]), d);
    end
    $display("test multiple done");
    end_sim();
  end
endmodule : tb

// [hw/fea_pkg.sv]
/*
  Package for the far-end alarm code receiver: register offsets, field positions,
  reset values, counts, the framing mode and tracking state codes, and the state record.
  Assumes the receive framer codes its framing mode as listed below.
*/
package fea_pkg;

  // ****************************************************************
  // Register map, byte addresses on the Avalon-MM slave
  // ****************************************************************
  localparam logic [4:0]  FEA_ADDR_CTRL   = 5'h00;
  localparam logic [4:0]  FEA_ADDR_STATUS = 5'h04;
  localparam logic [4:0]  FEA_ADDR_CODE   = 5'h08;
  localparam logic [4:0]  FEA_ADDR_STACK  = 5'h0C;

  // Control register fields and value after reset.
  localparam int          FEA_CTRL_SINGLE  = 0;
  localparam int          FEA_CTRL_MSG_IE  = 1;
  localparam int          FEA_CTRL_IDLE_IE = 2;
  localparam int          FEA_CTRL_SNE_IE  = 3;
  localparam logic [3:0]  FEA_CTRL_RESET   = 4'h0;

  // Status register fields.
  localparam int          FEA_STAT_NEW  = 0;
  localparam int          FEA_STAT_IDLE = 1;
  localparam int          FEA_STAT_SNE  = 2;
  localparam int          FEA_STAT_MSG  = 3;

  // Stack register fields above the six code bits.
  localparam int          FEA_STK_VALID = 6;
  localparam int          FEA_STK_MORE  = 7;

  // ****************************************************************
  // Counts
  // ****************************************************************
  localparam logic [4:0]  FEA_IDLE_ONES   = 5'h10;
  localparam logic [4:0]  FEA_VALID_COUNT = 5'h09;
  localparam logic [1:0]  FEA_STACK_DEPTH = 2'h3;
  localparam logic [7:0]  FEA_PAT_ONES    = 8'hFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0]
  {
    FEA_FRM_M13  = 3'h0,
    FEA_FRM_M23  = 3'h1,
    FEA_FRM_CBIT = 3'h2,
    FEA_FRM_G751 = 3'h3,
    FEA_FRM_G832 = 3'h4
  } fea_frm_type;

  typedef enum logic [1:0]
  {
    FEA_TRK_INIT = 2'b00,
    FEA_TRK_TENT = 2'b01,
    FEA_TRK_ALT  = 2'b11
  } fea_trk_type;

  typedef struct packed
  {
    logic [3:0]       ctrl;
    logic [15:0]      shreg;
    logic [4:0]       ones;
    fea_trk_type      trk;
    logic [5:0]       tent;
    logic [5:0]       alt;
    logic [3:0]       mcnt;
    logic             msg;
    logic             new_flag;
    logic             ret_flag;
    logic [7:0]       code_byte;
    logic [2:0][5:0]  stk;
    logic [1:0]       scnt;
    logic [5:0]       last_word;
    logic             was_idle;
    logic             ack;
    logic             wait_r;
    logic [31:0]      rdata;
    logic             irq;
  } fea_state_type;

endpackage : fea_pkg

// [hw/fea_receiver.sv]
/*
  Far-end alarm code receiver for one DS3 port: pattern and idle detection on the
  C13 overhead bit, single or nine-repeat tracking, message and idle flags, a
  three-entry code stack and an Avalon-MM register slave with waitrequest.
  Assumes the framer delivers each C13 bit with a one-cycle strobe on i_core_clk.
*/
// Summary of operation
// - Input is the C13 bit in C-bit parity.
// - Pattern 0xxxxxx011111111, six-bit code word proper.
// - Receiver disabled in M13, M23 and E3 modes.
// - Single mode: one pattern is a valid word.
// - Multiple mode: nine identical propers make valid.
// - First pattern: tentative word, counter one.
// - Match adds one; mismatch saves alternative word.
// - With alternative, tentative match adds two.
// - Alternative match promotes; neither match shifts both.
// - Exact compare, no overhead errors, gaps ignored.
// - Sixteen consecutive ones is a valid idle.
// - Valid word: code byte, new flag, message state.
// - Reading code byte clears new-message flag.
// - Message state: idle sets return flag, state idle.
// - Code byte unbuffered; new word overwrites.
// - Detection always on; three interrupt enables.
// - Three-entry code stack, always active.
// - Stack read: code, valid, more; empty reads zero.
// - Not-empty status raises interrupt unless masked.
// - Push on new word, empty stack, leaving idle.
// - Push onto full stack discards oldest.
`timescale 1ns/10ps
module fea_receiver
  import fea_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_oh_bit_valid,
  input  wire logic         i_oh_bit,
  input  wire logic [2:0]   i_framing_mode,
  input  wire logic [4:0]   i_avs_address,
  input  wire logic         i_avs_read,
  input  wire logic         i_avs_write,
  input  wire logic [31:0]  i_avs_writedata,
  output logic [31:0]       o_avs_readdata,
  output logic              o_avs_waitrequest,
  output logic              o_irq
);

  // ****************************************************************
  // State record
  // ****************************************************************
  fea_state_type st;
  fea_state_type next_st;

  logic        frm_on;
  logic        bit_take;
  logic [15:0] shift_in;
  logic        pat_hit;
  logic [5:0]  hit_code;
  logic        idle_hit;
  logic        valid_cw;
  logic [4:0]  tent_sum;
  logic        push;
  logic        pop;
  logic        rd_done;
  logic        wr_done;
  logic [5:0]  push_word;

  // The channel only exists in C-bit parity framing; elsewhere all detection is held off.
  assign frm_on   = (i_framing_mode == FEA_FRM_CBIT);
  assign bit_take = i_oh_bit_valid && frm_on;
  assign shift_in = {i_oh_bit, st.shreg[15:1]};

  // The oldest bit sits at the bottom, so the eight ones lead and the framing zeros close.
  // Exact compare: any overhead bit in error simply gives no hit.
  assign pat_hit  = bit_take && (shift_in[7:0] == FEA_PAT_ONES) && !shift_in[8]
                    && !shift_in[15];
  assign hit_code = shift_in[14:9];

  // Idle fires once, on the sixteenth one in a row.
  assign idle_hit = bit_take && i_oh_bit && (st.ones == (FEA_IDLE_ONES - 5'h01));

  // Bus effects take place at the edge where the master sees waitrequest low.
  assign rd_done  = st.ack && i_avs_read;
  assign wr_done  = st.ack && i_avs_write && (i_avs_address == FEA_ADDR_CTRL);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // All detection, tracking, flag, stack and bus behaviour is computed here.
  always_comb
  begin
    next_st   = st;
    valid_cw  = 1'b0;
    tent_sum  = 5'h00;
    push      = 1'b0;
    pop       = 1'b0;
    push_word = hit_code;

    // Software control; detection itself has no off switch.
    if (wr_done)
    begin
      next_st.ctrl = i_avs_writedata[3:0];
    end

    // Pattern shifter and run-of-ones counter.
    if (!frm_on)
    begin
      next_st.shreg = 16'h0000;
      next_st.ones  = 5'h00;
      next_st.trk   = FEA_TRK_INIT;
      next_st.mcnt  = 4'h0;
      next_st.msg   = 1'b0;
    end
    else if (bit_take)
    begin
      // After a hit the shifter restarts so no two patterns share bits; gaps are ignored.
      next_st.shreg = pat_hit ? 16'h0000 : shift_in;
      if (!i_oh_bit)
      begin
        next_st.ones = 5'h00;
      end
      else if (st.ones != FEA_IDLE_ONES)
      begin
        next_st.ones = st.ones + 5'h01;
      end
    end

    // Word detection: single mode or the repeat tracker.
    if (pat_hit)
    begin
      if (st.ctrl[FEA_CTRL_SINGLE])
      begin
        valid_cw = 1'b1;
      end
      else
      begin
        unique case (st.trk)
          FEA_TRK_INIT:
          begin
            next_st.tent = hit_code;
            next_st.mcnt = 4'h1;
            next_st.trk  = FEA_TRK_TENT;
          end
          FEA_TRK_TENT:
          begin
            if (hit_code == st.tent)
            begin
              tent_sum = {1'b0, st.mcnt} + 5'h01;
              if (tent_sum >= FEA_VALID_COUNT)
              begin
                valid_cw    = 1'b1;
                next_st.trk = FEA_TRK_INIT;
              end
              else
              begin
                next_st.mcnt = tent_sum[3:0];
              end
            end
            else
            begin
              next_st.alt = hit_code;
              next_st.trk = FEA_TRK_ALT;
            end
          end
          FEA_TRK_ALT:
          begin
            if (hit_code == st.tent)
            begin
              tent_sum = {1'b0, st.mcnt} + 5'h02;
              if (tent_sum >= FEA_VALID_COUNT)
              begin
                valid_cw    = 1'b1;
                next_st.trk = FEA_TRK_INIT;
              end
              else
              begin
                next_st.mcnt = tent_sum[3:0];
                next_st.trk  = FEA_TRK_TENT;
              end
            end
            else if (hit_code == st.alt)
            begin
              next_st.tent = st.alt;
              next_st.mcnt = 4'h2;
              next_st.trk  = FEA_TRK_TENT;
            end
            else
            begin
              next_st.tent = st.alt;
              next_st.mcnt = 4'h1;
              next_st.alt  = hit_code;
            end
          end
          default:
          begin
            next_st.trk = FEA_TRK_INIT;
          end
        endcase
      end
    end

    // Flag clears from software reads; a set in the same cycle below wins.
    // The new flag clears only if the byte read is still the one held, so a fresh
    // word landing between capture and read is not lost.
    if (rd_done && (i_avs_address == FEA_ADDR_CODE) && (st.rdata[7:0] == st.code_byte))
    begin
      next_st.new_flag = 1'b0;
    end
    if (rd_done && (i_avs_address == FEA_ADDR_STATUS) && st.rdata[FEA_STAT_IDLE])
    begin
      next_st.ret_flag = 1'b0;
    end

    // Message state machine; a valid word is handled the same in either state.
    if (valid_cw)
    begin
      next_st.code_byte = {1'b0, hit_code, 1'b0};
      next_st.new_flag  = 1'b1;
      next_st.msg       = 1'b1;
    end
    else if (idle_hit && st.msg)
    begin
      next_st.ret_flag = 1'b1;
      next_st.msg      = 1'b0;
    end

    // Remember an idle channel so the next word after it is always stacked.
    if (idle_hit)
    begin
      next_st.was_idle = 1'b1;
    end

    // Stack pushes and pops; the stack runs whatever the control bits say.
    push = valid_cw && ((hit_code != st.last_word) || (st.scnt == 2'h0)
                        || st.was_idle);
    pop  = rd_done && (i_avs_address == FEA_ADDR_STACK) && st.rdata[FEA_STK_VALID];
    if (pop && (next_st.scnt != 2'h0))
    begin
      next_st.stk[0] = next_st.stk[1];
      next_st.stk[1] = next_st.stk[2];
      next_st.scnt   = next_st.scnt - 2'h1;
    end
    if (push)
    begin
      if (next_st.scnt == FEA_STACK_DEPTH)
      begin
        // No overrun indication exists; the oldest unread word is simply lost.
        next_st.stk[0] = next_st.stk[1];
        next_st.stk[1] = next_st.stk[2];
        next_st.stk[2] = push_word;
      end
      else
      begin
        next_st.stk[next_st.scnt] = push_word;
        next_st.scnt              = next_st.scnt + 2'h1;
      end
      next_st.last_word = push_word;
      next_st.was_idle  = 1'b0;
    end

    // Bus slave: one wait cycle, then a one-cycle answer with registered data.
    next_st.ack    = (i_avs_read || i_avs_write) && !st.ack;
    next_st.wait_r = !next_st.ack;
    next_st.rdata  = 32'h0000_0000;
    if (next_st.ack && i_avs_read)
    begin
      unique case (i_avs_address)
        FEA_ADDR_CTRL:   next_st.rdata[3:0] = st.ctrl;
        FEA_ADDR_STATUS: next_st.rdata[3:0] = {st.msg, (st.scnt != 2'h0),
                                               st.ret_flag, st.new_flag};
        FEA_ADDR_CODE:   next_st.rdata[7:0] = st.code_byte;
        FEA_ADDR_STACK:
        begin
          // Empty stack: valid and more are zero and the code bits read as zero.
          if (st.scnt != 2'h0)
          begin
            next_st.rdata[5:0]           = st.stk[0];
            next_st.rdata[FEA_STK_VALID] = 1'b1;
            next_st.rdata[FEA_STK_MORE]  = (st.scnt > 2'h1);
          end
        end
        default:         next_st.rdata = 32'h0000_0000;
      endcase
    end

    // One interrupt line gathers the three masked sources.
    next_st.irq = (next_st.new_flag && next_st.ctrl[FEA_CTRL_MSG_IE])
                  || (next_st.ret_flag && next_st.ctrl[FEA_CTRL_IDLE_IE])
                  || ((next_st.scnt != 2'h0) && next_st.ctrl[FEA_CTRL_SNE_IE]);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Everything resets to constants; waitrequest rests high between accesses.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st           <= '0;
      st.ctrl      <= FEA_CTRL_RESET;
      st.trk       <= FEA_TRK_INIT;
      st.wait_r    <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_avs_readdata    = st.rdata;
  assign o_avs_waitrequest = st.wait_r;
  assign o_irq             = st.irq;

  // ****************************************************************
  // Assertions and covers
  // ****************************************************************
  default clocking fea_cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_single_word_byte: assert property (
    (pat_hit && st.ctrl[FEA_CTRL_SINGLE]) |=>
      (st.new_flag && st.msg && (st.code_byte == {1'b0, $past(hit_code), 1'b0})))
    else $error("single mode pattern did not load the code byte");

  a_mode_off_clear: assert property (
    (i_framing_mode != FEA_FRM_CBIT) |=> ((st.shreg == 16'h0000) && !st.msg))
    else $error("receiver active outside C-bit parity");

  a_nine_repeat: assert property (
    (valid_cw && !st.ctrl[FEA_CTRL_SINGLE]) |->
      ((tent_sum >= 5'h09) && (tent_sum <= 5'h0A)))
    else $error("multiple mode declared a word before nine patterns");

  a_alt_adds_two: assert property (
    (pat_hit && !st.ctrl[FEA_CTRL_SINGLE] && (st.trk == FEA_TRK_ALT)
     && (hit_code == st.tent) && (st.mcnt < 4'h7)) |=>
      ((st.mcnt == $past(st.mcnt) + 4'h2) && (st.trk == FEA_TRK_TENT)))
    else $error("tentative match with alternative held did not add two");

  // The run counter must stand saturated after the match, so the idle fires only once.
  a_idle_run: assert property (
    idle_hit |-> (st.ones == (FEA_IDLE_ONES - 5'h01)) ##1 (st.ones == FEA_IDLE_ONES))
    else $error("idle declared without sixteen ones");

  a_idle_return: assert property (
    (st.msg && idle_hit && !valid_cw) |=> (!st.msg && st.ret_flag)[*2])
    else $error("idle in message state did not return to idle");

  a_full_stack: assert property (
    (push && !pop && (st.scnt == 2'h3)) |=>
      ((st.scnt == 2'h3) && (st.stk[2] == $past(hit_code))))
    else $error("push onto full stack lost the new word");

  a_more_needs_valid: assert property (
    (!o_avs_waitrequest && $past(i_avs_address == FEA_ADDR_STACK))
      |-> (!o_avs_readdata[FEA_STK_MORE] || o_avs_readdata[FEA_STK_VALID]))
    else $error("stack more bit set without valid");

  a_new_flag_clear: assert property (
    (rd_done && (i_avs_address == FEA_ADDR_CODE) && (st.rdata[7:0] == st.code_byte)
     && !valid_cw) |=> !st.new_flag)
    else $error("code byte read did not clear the new flag");

  c_single_word: cover property (pat_hit && st.ctrl[FEA_CTRL_SINGLE]);
  c_nine_valid: cover property (valid_cw && !st.ctrl[FEA_CTRL_SINGLE]);
  c_stack_full_push: cover property (push && (st.scnt == 2'h3));
  c_return_idle: cover property (st.msg && idle_hit);

endmodule : fea_receiver
